// File: design/gio_io_logic.sv
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module gio_io_logic
  import gio_pkg::*;
#(
  parameter int ADDR_W         = 4,
  parameter bit HIGH_SPEED_PAD = 1'b1
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // core fabric
  input  wire logic [3:0]        coreOut,
  input  wire logic              coreOe,
  input  wire logic              sampleClock,
  input  wire logic              driveClock,
  input  wire logic              clkTree,
  output logic [3:0]             coreIn,
  output logic                   altOut,
  // pad
  input  wire logic              padI,
  output logic                   padO,
  output logic                   padOe,
  output logic                   pullUpEn,
  output logic                   pullDownEn
);

  logic [CTRL_W-1:0] ctrl_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              scLast_q;
  logic              dcLast_q;
  logic              inQ_q;
  logic              riseQ_q;
  logic              fallQ_q;
  logic              alignRise_q;
  logic              alignFall_q;
  logic [3:0]        deShift_q;
  logic [3:0]        deWord_q;
  logic [1:0]        deCnt_q;
  logic              outQ_q;
  logic              dHiQ_q;
  logic              dLoQ_q;
  logic              oeQ_q;
  logic [3:0]        serHold_q;
  logic              serBit_q;
  logic [1:0]        serCnt_q;
  logic              wrGo;
  logic              rdGo;
  logic [31:0]       wMask;
  logic [31:0]       statWord;
  logic              sRise;
  logic              sFall;
  logic              dRise;
  logic              dFall;
  logic              inSel;
  logic              outSel;
  logic              oeSel;
  logic              inActive;
  logic              outActive;
  logic              serOn;
  logic              userMode;
  logic              ddioIn;
  logic              ddioOut;
  logic              regd;
  logic              ddioBit;
  logic              dataVal;
  logic              driveVal;
  logic              oeEff;
  gio_mode_t         mode;
  gio_align_t        align;

  // ---- axi4-lite slave
  assign wrGo          = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rdGo          = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wrGo;
  assign s_axi_wready  = wrGo;
  assign s_axi_arready = rdGo;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign statWord = {24'h000000, deWord_q, fallQ_q, riseQ_q, padOe, padI};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wrGo) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (s_axi_awaddr == ADDR_W'(CTRL_OFFS)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (wrGo && s_axi_awaddr == ADDR_W'(CTRL_OFFS)) begin
      ctrl_q <= (ctrl_q & ~wMask[CTRL_W-1:0]) | (s_axi_wdata[CTRL_W-1:0] & wMask[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end else if (rdGo) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(CTRL_OFFS)) begin
        rdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
      end else if (s_axi_araddr == ADDR_W'(STAT_OFFS)) begin
        rdata_q <= statWord;
      end else begin
        rdata_q <= 32'h00000000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---- configuration decode
  assign mode     = gio_mode_t'(ctrl_q[F_MODE +: 3]);
  assign align    = gio_align_t'(ctrl_q[F_ALIGN +: 2]);
  assign userMode = ctrl_q[F_USER_MODE];
  assign ddioIn   = ctrl_q[F_DOUBLE_EDGE_IO_IN];
  assign ddioOut  = ctrl_q[F_DOUBLE_EDGE_IO_OUT];
  assign inActive  = userMode & (mode == GIO_INPUT || mode == GIO_BIDIR);
  assign outActive = userMode & (mode == GIO_OUTPUT || mode == GIO_BIDIR);
  // serdes exists on the high-speed variant only, never with double-edge
  assign serOn = HIGH_SPEED_PAD & ctrl_q[F_SERDES] & ~ddioIn & ~ddioOut;

  // ---- clock edge detection on the sampled fabric clocks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scLast_q <= 1'b0;
      dcLast_q <= 1'b0;
    end else begin
      scLast_q <= sampleClock;
      dcLast_q <= driveClock;
    end
  end
  assign sRise  = sampleClock & ~scLast_q;
  assign sFall  = ~sampleClock & scLast_q;
  assign dRise  = driveClock & ~dcLast_q;
  assign dFall  = ~driveClock & dcLast_q;
  assign inSel  = ctrl_q[F_IN_EDGE] ? sFall : sRise;
  assign outSel = ctrl_q[F_OUT_EDGE] ? dFall : dRise;
  assign oeSel  = ctrl_q[F_OE_EDGE] ? dFall : dRise;

  // ---- receive registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      inQ_q       <= 1'b0;
      riseQ_q     <= 1'b0;
      fallQ_q     <= 1'b0;
      alignRise_q <= 1'b0;
      alignFall_q <= 1'b0;
    end else if (inActive) begin
      if (inSel) inQ_q <= padI;
      if (sRise) riseQ_q <= padI;
      if (sFall) fallQ_q <= padI;
      if (sRise) begin
        alignRise_q <= riseQ_q;
        alignFall_q <= fallQ_q;
      end
    end
  end

  // deserializer: first bit lands in bit 0
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      deShift_q <= 4'h0;
      deWord_q  <= 4'h0;
      deCnt_q   <= 2'h0;
    end else if (inActive && serOn && inSel) begin
      deShift_q <= {padI, deShift_q[3:1]};
      deCnt_q   <= deCnt_q + 2'h1;
      if (deCnt_q == 2'(SER_RATIO - 1)) deWord_q <= {padI, deShift_q[3:1]};
    end
  end

  always_comb begin
    coreIn = 4'h0;
    if (!inActive) begin
      coreIn = 4'h0;
    end else if (serOn) begin
      coreIn = deWord_q;
    end else if (ddioIn) begin
      unique case (align)
        ALIGN_RESYNC: coreIn = {2'h0, alignFall_q, riseQ_q};
        ALIGN_PIPE:   coreIn = {2'h0, alignFall_q, alignRise_q};
        default:      coreIn = {2'h0, fallQ_q, riseQ_q};
      endcase
    end else begin
      coreIn = {3'h0, ctrl_q[F_IN_REG] ? inQ_q : padI};
    end
  end

  // alternate path: pure wire, only in alternate-input mode
  assign altOut = (userMode && mode == GIO_ALTIN) ? padI : 1'b0;

  // ---- drive registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      outQ_q <= 1'b0;
      dHiQ_q <= 1'b0;
      dLoQ_q <= 1'b0;
      oeQ_q  <= 1'b0;
    end else if (outActive) begin
      if (outSel) outQ_q <= coreOut[0];
      if (dRise) dHiQ_q <= coreOut[0];
      if (dFall) dLoQ_q <= coreOut[1];
      if (oeSel) oeQ_q <= coreOe;
    end
  end

  // serializer: word loaded every fourth edge, bit 0 first
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serHold_q <= 4'h0;
      serBit_q  <= 1'b0;
      serCnt_q  <= 2'h0;
    end else if (outActive && serOn && outSel) begin
      serCnt_q <= serCnt_q + 2'h1;
      serBit_q <= (serCnt_q == 2'h0) ? coreOut[0] : serHold_q[serCnt_q];
      if (serCnt_q == 2'h0) serHold_q <= coreOut;
    end
  end

  assign ddioBit  = dcLast_q ? dHiQ_q : dLoQ_q;
  assign regd     = serOn | ddioOut | ctrl_q[F_OUT_REG];
  assign dataVal  = serOn ? serBit_q : ddioOut ? ddioBit :
                    ctrl_q[F_OUT_REG] ? outQ_q : coreOut[0];
  assign driveVal = dataVal ^ (ctrl_q[F_OUT_INV] & regd);

  always_comb begin
    oeEff = 1'b0;
    if (userMode) begin
      unique case (mode)
        GIO_CLKOUT:            oeEff = 1'b1;
        GIO_OUTPUT, GIO_BIDIR: oeEff = ctrl_q[F_OE_REG] ? oeQ_q : coreOe;
        default:               oeEff = 1'b0;
      endcase
    end
  end

  assign padOe = oeEff;
  assign padO  = !oeEff ? 1'b0 : (mode == GIO_CLKOUT) ? clkTree : driveVal;
  assign pullUpEn   = ~userMode | (mode == GIO_UNUSED & ~ctrl_q[F_PULL_DOWN]);
  assign pullDownEn = userMode & mode == GIO_UNUSED & ctrl_q[F_PULL_DOWN];

  // ---- checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_alt_wire: assert property (userMode && mode == GIO_ALTIN |-> altOut == padI)
    else $error("alternate path not combinational");
  chk_in_off: assert property (!inActive |-> coreIn == 4'h0)
    else $error("receive path active outside input modes");
  chk_in_hold: assert property (inActive && !inSel |=> $stable(inQ_q))
    else $error("input register moved without sample edge");
  chk_rise_capture: assert property (inActive && sRise |=> riseQ_q == $past(padI))
    else $error("rising sample lost");
  chk_double_edge_io_bits: assert property (inActive && ddioIn && !serOn && align == ALIGN_NORMAL
                   |-> coreIn[1:0] == {fallQ_q, riseQ_q})
    else $error("double-edge bit order wrong");
  chk_resync_stable: assert property (inActive && ddioIn && !serOn && align == ALIGN_RESYNC
                       && !sRise |=> $stable(coreIn[1:0]))
    else $error("resync data changed off rising edge");
  chk_out_capture: assert property (outActive && outSel |=> outQ_q == $past(coreOut[0]))
    else $error("output register missed drive edge");
  chk_out_invert: assert property (mode == GIO_OUTPUT && padOe && ctrl_q[F_OUT_REG] && !ddioOut
                    && !serOn |-> padO == (outQ_q ^ ctrl_q[F_OUT_INV]))
    else $error("output inversion wrong");
  chk_double_edge_io_mux: assert property (outActive && ddioOut && padOe && mode != GIO_CLKOUT
                  |-> padO == ((dcLast_q ? dHiQ_q : dLoQ_q) ^ ctrl_q[F_OUT_INV]))
    else $error("double-edge drive mux wrong");
  chk_clk_out: assert property (userMode && mode == GIO_CLKOUT |-> padOe && padO == clkTree)
    else $error("clock output not from clock tree");
  chk_oe_hold: assert property (outActive && !oeSel |=> $stable(oeQ_q))
    else $error("enable register moved without drive edge");
  chk_cfg_pull: assert property (!userMode |-> pullUpEn && !pullDownEn && !padOe)
    else $error("pad not pulled up during configuration");
  chk_unused_pull: assert property (userMode && mode == GIO_UNUSED
                     |-> !padOe && (pullUpEn != pullDownEn)
                     && pullDownEn == ctrl_q[F_PULL_DOWN])
    else $error("unused pad pull wrong");
  chk_tristate: assert property (!padOe |-> !padO)
    else $error("pad driven while disabled");
  chk_no_serdes: assert property (!HIGH_SPEED_PAD |-> !serOn)
    else $error("serdes on without high-speed pad");
  chk_in_only: assert property (userMode && mode == GIO_INPUT |-> !padOe)
    else $error("driver on in input mode");
  chk_out_only: assert property (userMode && mode == GIO_OUTPUT |-> coreIn == 4'h0)
    else $error("receive path active in output mode");
  chk_alt_off: assert property (!(userMode && mode == GIO_ALTIN) |-> !altOut)
    else $error("alternate path active outside alternate mode");
  chk_fall_capture: assert property (inActive && sFall |=> fallQ_q == $past(padI))
    else $error("falling sample lost");
  chk_resync_delay: assert property (inActive && sRise |=> alignFall_q == $past(fallQ_q))
    else $error("falling sample not realigned at rising edge");
  chk_ser_load: assert property (outActive && serOn && outSel && serCnt_q == 2'h0
                  |=> serBit_q == $past(coreOut[0]) && serHold_q == $past(coreOut))
    else $error("serializer did not start with bit 0");
  chk_des_last: assert property (inActive && serOn && inSel && deCnt_q == 2'h3
                  |=> deWord_q[3] == $past(padI))
    else $error("deserializer last bit not in bit 3");

  cov_double_edge_io_in: cover property (inActive && ddioIn && sRise ##[1:20] sFall);
  cov_bidir_drive: cover property (mode == GIO_BIDIR && padOe ##1 !padOe);
  cov_ser_word: cover property (serOn && inActive && inSel && deCnt_q == 2'h3);
  cov_clk_out: cover property (userMode && mode == GIO_CLKOUT && padO);
  cov_ser_out: cover property (outActive && serOn && outSel && serCnt_q == 2'h3);
endmodule : gio_io_logic
`default_nettype wire

// File: design/gio_pkg.sv
package gio_pkg;
  // register byte addresses
  localparam logic [3:0]  CTRL_OFFS   = 4'h0;
  localparam logic [3:0]  STAT_OFFS   = 4'h4;
  // control field positions
  localparam int          F_MODE      = 0;
  localparam int          F_IN_REG    = 3;
  localparam int          F_IN_EDGE   = 4;
  localparam int          F_OUT_REG   = 5;
  localparam int          F_OUT_EDGE  = 6;
  localparam int          F_OE_REG    = 7;
  localparam int          F_OE_EDGE   = 8;
  localparam int          F_OUT_INV   = 9;
  localparam int          F_DOUBLE_EDGE_IO_IN   = 10;
  localparam int          F_DOUBLE_EDGE_IO_OUT  = 11;
  localparam int          F_ALIGN     = 12;
  localparam int          F_PULL_DOWN = 14;
  localparam int          F_USER_MODE = 15;
  localparam int          F_SERDES    = 16;
  localparam int          CTRL_W      = 17;
  localparam logic [16:0] CTRL_RST    = 17'h00000;
  // serializer ratio
  localparam int          SER_RATIO   = 4;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    GIO_UNUSED, GIO_INPUT, GIO_OUTPUT, GIO_BIDIR, GIO_CLKOUT, GIO_ALTIN
  } gio_mode_t;

  typedef enum logic [1:0] {ALIGN_NORMAL, ALIGN_RESYNC, ALIGN_PIPE} gio_align_t;
endpackage : gio_pkg

// File: testbench/gio_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module gio_fabric_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // scenario control
  input  wire logic       run,
  input  wire logic [1:0] padSel,
  input  wire logic       padLevel,
  // block pins
  input  wire logic       padO,
  input  wire logic       padOe,
  input  wire logic       pullUpEn,
  input  wire logic       pullDownEn,
  output logic            sampleClock,
  output logic            driveClock,
  output logic            padI
);
  logic [1:0] phase_q;
  logic       last_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 2'h0;
    end else if (!run) begin
      // restart the phase so the first rise always comes on the second edge after run
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  // fabric clocks stand low while stopped
  assign sampleClock = run & phase_q[1];
  assign driveClock  = run & phase_q[1];
  always_ff @(posedge ref_clk) begin
    last_q <= padI;
  end
  // block driver wins, then outside driver, then weak pull, else the level drifts
  always_comb begin
    if (padOe) begin
      padI = padO;
    end else if (padSel == 2'h1) begin
      padI = padLevel;
    end else if (padSel == 2'h2) begin
      padI = sampleClock;
    end else if (pullUpEn) begin
      padI = 1'b1;
    end else if (pullDownEn) begin
      padI = 1'b0;
    end else begin
      padI = ~last_q;
    end
  end
endmodule : gio_fabric_model
`default_nettype wire

// File: testbench/tb_gio_io_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gio_io_logic;
  import gio_pkg::*;
  localparam logic [31:0] U = 32'h1 << F_USER_MODE;
  logic ref_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, coreOut, coreIn;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, padSel;
  logic coreOe, sampleClock, driveClock, clkTree, altOut, padI, padO, padOe;
  logic pullUpEn, pullDownEn, run, padLevel;
  int errors, checks, cycles, ones;
  gio_io_logic u_gio_io_logic (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .coreOut, .coreOe, .sampleClock, .driveClock, .clkTree,
    .coreIn, .altOut, .padI, .padO, .padOe, .pullUpEn, .pullDownEn);
  gio_fabric_model u_gio_fabric_model (.ref_clk, .rstn, .run, .padSel, .padLevel, .padO,
    .padOe, .pullUpEn, .pullDownEn, .sampleClock, .driveClock, .padI);
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    chk(32'(s_axi_bresp), 32'(r), "write response");
    s_axi_bready <= 1'b0;
    step(1);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    chk(s_axi_rdata, d, "read data");
    chk(32'(s_axi_rresp), 32'(r), "read response");
    s_axi_rready <= 1'b0;
    step(1);
  endtask : axi_read
  task automatic set_pins(input logic r, input logic [1:0] s, input logic l, input logic [3:0] o,
                          input logic e);
    run <= r;
    padSel <= s;
    padLevel <= l;
    coreOut <= o;
    coreOe <= e;
    step(1);
  endtask : set_pins
  task automatic test_regs_and_pulls();
    set_pins(1'b0, 2'h0, 1'b0, 4'h1, 1'b1);
    chk(32'({pullUpEn, pullDownEn, padOe}), 32'h4, "pulls in configuration");
    axi_read(CTRL_OFFS, 32'h0, RESP_OKAY);
    axi_write(CTRL_OFFS, 32'h2, RESP_OKAY);
    chk(32'({pullUpEn, padOe}), 32'h2, "still configuring");
    axi_write(STAT_OFFS, 32'hffff, RESP_SLVERR);
    axi_write(4'h8, 32'h1, RESP_SLVERR);
    axi_read(4'hc, 32'h0, RESP_SLVERR);
    axi_write(CTRL_OFFS, U, RESP_OKAY);
    axi_read(CTRL_OFFS, U, RESP_OKAY);
    chk(32'({pullUpEn, pullDownEn, padOe}), 32'h4, "unused pad");
    axi_write(CTRL_OFFS, U | (32'h1 << F_PULL_DOWN), RESP_OKAY);
    chk(32'({pullUpEn, pullDownEn, padOe}), 32'h2, "unused pull-down");
  endtask : test_regs_and_pulls
  task automatic test_input();
    axi_write(CTRL_OFFS, U | 32'h1, RESP_OKAY);
    set_pins(1'b0, 2'h1, 1'b1, 4'h0, 1'b1);
    chk(32'({coreIn[0], padOe}), 32'h2, "direct input");
    axi_write(CTRL_OFFS, U | 32'h1 | (32'h1 << F_IN_REG), RESP_OKAY);
    set_pins(1'b1, 2'h1, 1'b0, 4'h0, 1'b1);
    step(8);
    set_pins(1'b0, 2'h1, 1'b1, 4'h0, 1'b1);
    step(4);
    chk(32'(coreIn[0]), 32'h0, "held while clock stopped");
    set_pins(1'b1, 2'h1, 1'b1, 4'h0, 1'b1);
    step(8);
    chk(32'(coreIn[0]), 32'h1, "captured on clock");
    axi_write(CTRL_OFFS, U | 32'h1 | (32'h1 << F_IN_REG) | (32'h1 << F_IN_EDGE), RESP_OKAY);
    set_pins(1'b1, 2'h2, 1'b0, 4'h0, 1'b1);
    step(8);
    chk(32'(coreIn[0]), 32'h0, "falling-edge capture");
    for (int al = 0; al < 3; al++) begin
      axi_write(CTRL_OFFS, U | 32'h1 | (32'h1 << F_IN_REG) | (32'h1 << F_DOUBLE_EDGE_IO_IN) |
                (32'(al) << F_ALIGN), RESP_OKAY);
      set_pins(1'b1, 2'h2, 1'b0, 4'h0, 1'b0);
      step(16);
      chk(32'(coreIn[1:0]), 32'h1, "double-edge receive bits");
    end
  endtask : test_input
  task automatic test_alt_and_clock();
    axi_write(CTRL_OFFS, U | 32'h5, RESP_OKAY);
    for (int v = 0; v < 2; v++) begin
      set_pins(1'b0, 2'h1, v[0], 4'h0, 1'b1);
      chk(32'({altOut, padOe}), 32'(v * 2), "alternate input");
    end
    axi_write(CTRL_OFFS, U | 32'h4, RESP_OKAY);
    for (int v = 0; v < 2; v++) begin
      clkTree <= v[0];
      set_pins(1'b0, 2'h0, 1'b0, 4'(~v), 1'b0);
      chk(32'({padO, padOe}), 32'(v * 2 + 1), "clock output");
    end
  endtask : test_alt_and_clock
  task automatic test_output();
    axi_write(CTRL_OFFS, U | 32'h2 | (32'h1 << F_OUT_INV), RESP_OKAY);
    set_pins(1'b0, 2'h0, 1'b0, 4'h1, 1'b1);
    chk(32'({padO, padOe}), 32'h3, "direct drive");
    set_pins(1'b0, 2'h1, 1'b0, 4'h1, 1'b0);
    chk(32'({padO, padOe}), 32'h0, "driver off");
    axi_write(CTRL_OFFS, U | 32'h2 | (32'h1 << F_OUT_REG) | (32'h1 << F_OUT_INV) |
              (32'h1 << F_OE_REG), RESP_OKAY);
    set_pins(1'b0, 2'h1, 1'b0, 4'h1, 1'b1);
    step(4);
    chk(32'(padOe), 32'h0, "enable register waits for clock");
    set_pins(1'b1, 2'h1, 1'b0, 4'h1, 1'b1);
    step(8);
    chk(32'({padO, padOe}), 32'h1, "inverted registered drive");
    for (int w = 1; w < 4; w += 2) begin
      axi_write(CTRL_OFFS, U | 32'h2 | (32'h1 << F_OUT_REG) | (32'h1 << F_DOUBLE_EDGE_IO_OUT), RESP_OKAY);
      set_pins(1'b1, 2'h1, 1'b0, 4'(w), 1'b1);
      step(8);
      ones = 0;
      repeat (16) begin
        step(1);
        ones += int'(padO === 1'b1);
      end
      chk(32'(ones), (w == 3) ? 32'd16 : 32'd8, "double-edge drive");
    end
  endtask : test_output
  task automatic test_bidir();
    axi_write(CTRL_OFFS, U | 32'h3 | (32'h1 << F_IN_REG) | (32'h1 << F_IN_EDGE), RESP_OKAY);
    for (int v = 0; v < 2; v++) begin
      set_pins(1'b1, 2'h1, 1'b0, 4'(v), 1'b1);
      step(8);
      chk(32'({padO, padOe, coreIn[0]}), 32'(v * 5 + 2), "bidirectional loop");
    end
    set_pins(1'b1, 2'h1, 1'b0, 4'h1, 1'b0);
    step(8);
    chk(32'({padOe, coreIn[0]}), 32'h0, "bidirectional receive");
  endtask : test_bidir
  task automatic test_serdes();
    logic [3:0] got;
    set_pins(1'b0, 2'h1, 1'b0, 4'h3, 1'b1);
    axi_write(CTRL_OFFS, U | 32'h1 | (32'h1 << F_SERDES), RESP_OKAY);
    // one sample-clock rise per four-cycle window, word 4'h3 sent bit 0 first
    for (int i = 0; i < 4; i++) begin
      set_pins(1'b1, 2'h1, i < 2, 4'h3, 1'b1);
      step(3);
    end
    set_pins(1'b0, 2'h1, 1'b0, 4'h3, 1'b1);
    chk(32'(coreIn), 32'h3, "deserialized word");
    axi_read(STAT_OFFS, 32'h30, RESP_OKAY);
    axi_write(CTRL_OFFS, U | 32'h2 | (32'h1 << F_SERDES), RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      set_pins(1'b1, 2'h1, 1'b0, 4'h3, 1'b1);
      step(3);
      got[i] = padO;
    end
    chk(32'(got), 32'h3, "serialized word");
  endtask : test_serdes
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, clkTree, run, padSel, padLevel} = '0;
    {coreOut, coreOe} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    test_regs_and_pulls();
    test_input();
    test_alt_and_clock();
    test_output();
    test_bidir();
    test_serdes();
    end_of_test();
  end
endmodule : tb_gio_io_logic
`default_nettype wire
